// [logic/adc_seq_cfg.svh]
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_PIN_CFG 8'hAE
`define IDX_REF_SEL 8'hAF
`define IDX_CTL 8'hB1
`define IDX_RES_HI 8'hB2
`define IDX_CLK_RES 8'hB3
`define IDX_IRQ_STAT 8'hB4
`define IDX_IRQ_MASK 8'hB5

// ==========================================================
// Field positions
`define CTL_ENABLE 7
`define CTL_START 6
`define CTL_DONE 5
`define CTL_GATE 4
`define CLK_DIV_HI 6
`define CLK_DIV_LO 4
`define REF_EXT 7
`define IRQ_DONE 0

// ==========================================================
// Reset values and codes
`define CTL_RST 8'h00
`define PIN_RST 5'h00
`define REF_LVL_RST 2'h0
`define DIV_RST 2'h0
`define REF_LVL_SUPPLY 2'h3
`define DIV_16 2'h0
`define DIV_8 2'h1
`define DIV_1 2'h2
`define DIV_2 2'h3
`define DIV_TERM_16 4'hF
`define DIV_TERM_8 4'h7
`define DIV_TERM_2 4'h1
`define DIV_TERM_1 4'h0

// ==========================================================
// Timing: sixteen periods of converter clock / 4
`define CONV_PERIODS 16
`define CONV_PRESCALE 4
`define CONV_TICKS (`CONV_PERIODS * `CONV_PRESCALE)
`define CONV_LAST 6'h3F

`endif

// [logic/adc_seq_pkg.sv]
package adc_seq_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } conv_state_e;

  // Steering for the analog core and pin pads
  typedef struct packed {
    logic converter_enable;
    logic channel_gate;
    logic [2:0] input_select;
    logic external_reference_enable;
    logic [1:0] reference_level_select;
    logic high_res;
    logic converting;
  } analog_ctl_s;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [9:0] adr;
    logic [31:0] dat;
  } wb_req_s;

endpackage : adc_seq_pkg

// [logic/conv_clock_divider.sv]
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

module conv_clock_divider (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [1:0] code_i,
  output logic tick_o
);

  logic [3:0] cnt_q;
  logic [3:0] term;

  function automatic logic [3:0] div_term(input logic [1:0] code);
    case (code)
      `DIV_16: div_term = `DIV_TERM_16;
      `DIV_8: div_term = `DIV_TERM_8;
      `DIV_1: div_term = `DIV_TERM_1;
      default: div_term = `DIV_TERM_2;
    endcase
  endfunction : div_term

  assign term = div_term(code_i);
  assign tick_o = run_i && (cnt_q == term);

  // Counter restarts from zero each conversion so the first tick is a full period
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i || tick_o) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  chk_div_undivided: assert property (@(posedge clk_i) disable iff (rst_i)
    (run_i && code_i == `DIV_1) |-> tick_o)
    else $error("undivided clock missed a tick");

  chk_div_sixteen: assert property (@(posedge clk_i) disable iff (rst_i)
    (tick_o && run_i && code_i == `DIV_16 && $stable(code_i)) |=> !tick_o [*8])
    else $error("divide by sixteen ticked early");

endmodule : conv_clock_divider

// [logic/adc_sequencer_regs.sv]
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"

// What this block does
// - Six inputs, twelve-bit result of 4096 steps
// - Start needs enable and start bits; gate not checked
// - Completion sets done, result in two registers
// - Control bit 7 enables converter, reset clears
// - Control bit 6 written one starts conversion
// - Done reads 0 busy, 1 after; start cleared
// - Control bit 4 connects selected input channel when bit 7 set
// - Bits 2..0 pick inputs 0-4 or quarter-supply
// - Divide code picks /16, /8, /1, /2
// - Clock/result low nibble read-only result bits
// - High-byte register read-only result bits 11..4
// - Eight-bit mode fills high byte only
// - Fixed references give 8 bits, else 12
// - Reference level field, resets to 2.0V code
// - External reference bit isolates input-zero pin
// - Pin config bit isolates digital pin use
// - Conversion lasts 64 converter clock ticks

module adc_sequencer_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [11:0] conv_data_i,
  output adc_seq_pkg::analog_ctl_s ana_o,
  output logic [4:0] pin_isolate_o,
  output logic irq_o
);

  // ==========================================================
  // Bus slave
  adc_seq_pkg::wb_req_s req;
  logic ack_q;
  logic [31:0] dat_q;
  logic take;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wdat;
  logic [7:0] rd_mux;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: wb_adr_i, dat: wb_dat_i};
  assign idx = req.adr[9:2];
  assign wdat = req.dat[7:0];
  // Writes land on the edge where the master sees ack
  assign take = req.cyc && req.stb && ack_q;
  assign wr = take && req.we && req.sel[0];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_idx);
    hit = (a == reg_idx);
  endfunction : hit

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req.cyc && req.stb && !ack_q;
    end
  end

  // ==========================================================
  // Register state
  logic en_q;
  logic start_q;
  logic done_q;
  logic gate_q;
  logic [2:0] chan_q;
  logic [1:0] div_q;
  logic [4:0] pin_q;
  logic ext_ref_q;
  logic [1:0] lvl_q;
  logic [7:0] res_hi_q;
  logic [3:0] res_lo_q;
  logic ist_q;
  logic imk_q;
  logic high_res;

  adc_seq_pkg::conv_state_e state_q;
  logic [5:0] tick_cnt_q;
  logic tick;
  logic launch;
  logic abort;
  logic conv_end;

  assign launch = (state_q == adc_seq_pkg::ST_IDLE) && en_q && start_q;
  assign abort = (state_q == adc_seq_pkg::ST_CONV) && !(en_q && start_q);
  assign conv_end = (state_q == adc_seq_pkg::ST_CONV) && !abort && tick
                    && (tick_cnt_q == `CONV_LAST);
  assign high_res = ext_ref_q || (lvl_q == `REF_LVL_SUPPLY);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      gate_q <= 1'b0;
      chan_q <= 3'h0;
    end else if (wr && hit(idx, `IDX_CTL)) begin
      en_q <= wdat[`CTL_ENABLE];
      gate_q <= wdat[`CTL_GATE];
      chan_q <= wdat[2:0];
    end
  end

  // Completion clears start even against a same-cycle write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_q <= 1'b0;
    end else if (conv_end) begin
      start_q <= 1'b0;
    end else if (wr && hit(idx, `IDX_CTL)) begin
      start_q <= wdat[`CTL_START];
    end
  end

  // Hardware set of done wins over a software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
    end else if (conv_end) begin
      done_q <= 1'b1;
    end else if (launch) begin
      done_q <= 1'b0;
    end else if (wr && hit(idx, `IDX_CTL) && (state_q != adc_seq_pkg::ST_CONV)) begin
      // A software write of done is ignored while busy so that done reads 0 then
      done_q <= wdat[`CTL_DONE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= `DIV_RST;
    end else if (wr && hit(idx, `IDX_CLK_RES)) begin
      div_q <= {wdat[`CLK_DIV_HI], wdat[`CLK_DIV_LO]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= `PIN_RST;
    end else if (wr && hit(idx, `IDX_PIN_CFG)) begin
      pin_q <= wdat[4:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_ref_q <= 1'b0;
      lvl_q <= `REF_LVL_RST;
    end else if (wr && hit(idx, `IDX_REF_SEL)) begin
      ext_ref_q <= wdat[`REF_EXT];
      lvl_q <= wdat[1:0];
    end
  end

  // Results change only at completion; contents after reset carry no meaning
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_hi_q <= 8'h00;
      res_lo_q <= 4'h0;
    end else if (conv_end) begin
      res_hi_q <= conv_data_i[11:4];
      res_lo_q <= high_res ? conv_data_i[3:0] : 4'h0;
    end
  end

  // ==========================================================
  // Conversion sequencer
  conv_clock_divider u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(state_q == adc_seq_pkg::ST_CONV),
    .code_i(div_q),
    .tick_o(tick)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= adc_seq_pkg::ST_IDLE;
    end else begin
      case (state_q)
        adc_seq_pkg::ST_IDLE: begin
          if (launch) begin
            state_q <= adc_seq_pkg::ST_CONV;
          end
        end
        adc_seq_pkg::ST_CONV: begin
          if (abort || conv_end) begin
            state_q <= adc_seq_pkg::ST_IDLE;
          end
        end
        default: state_q <= adc_seq_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != adc_seq_pkg::ST_CONV) begin
      tick_cnt_q <= 6'h00;
    end else if (tick) begin
      tick_cnt_q <= tick_cnt_q + 6'h01;
    end
  end

  // ==========================================================
  // Interrupt status and mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist_q <= 1'b0;
    end else if (conv_end) begin
      ist_q <= 1'b1;
    end else if (take && !req.we && hit(idx, `IDX_IRQ_STAT) && dat_q[`IRQ_DONE]) begin
      // Only a bit that the read returned is cleared
      ist_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      imk_q <= 1'b0;
    end else if (wr && hit(idx, `IDX_IRQ_MASK)) begin
      imk_q <= wdat[`IRQ_DONE];
    end
  end

  assign irq_o = ist_q && imk_q;

  // ==========================================================
  // Read path, captured a cycle ahead of ack
  always_comb begin
    rd_mux = 8'h00;
    case (idx)
      `IDX_CTL: rd_mux = {en_q, start_q, done_q, gate_q, 1'b0, chan_q};
      `IDX_CLK_RES: rd_mux = {1'b0, div_q[1], 1'b0, div_q[0], res_lo_q};
      `IDX_RES_HI: rd_mux = res_hi_q;
      `IDX_PIN_CFG: rd_mux = {3'h0, pin_q};
      `IDX_REF_SEL: rd_mux = {ext_ref_q, 5'h00, lvl_q};
      `IDX_IRQ_STAT: rd_mux = {7'h00, ist_q};
      `IDX_IRQ_MASK: rd_mux = {7'h00, imk_q};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req.cyc && req.stb && !ack_q) begin
      dat_q <= {24'h00_0000, rd_mux};
    end
  end

  // ==========================================================
  // Analog and pad steering
  assign ana_o.converter_enable = en_q;
  assign ana_o.channel_gate = gate_q && en_q;
  assign ana_o.input_select = chan_q;
  assign ana_o.external_reference_enable = ext_ref_q;
  assign ana_o.reference_level_select = lvl_q;
  assign ana_o.high_res = high_res;
  assign ana_o.converting = (state_q == adc_seq_pkg::ST_CONV);

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_pin
      if (gi == 0) begin : g_ref_pin
        assign pin_isolate_o[gi] = pin_q[gi] || ext_ref_q;
      end else begin : g_plain_pin
        assign pin_isolate_o[gi] = pin_q[gi];
      end
    end
  endgenerate

  // ==========================================================
  // Checks
  logic [6:0] chk_ticks_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || launch) begin
      chk_ticks_q <= 7'h00;
    end else if (tick) begin
      chk_ticks_q <= chk_ticks_q + 7'h01;
    end
  end

  chk_end_done_start: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_end |=> (done_q && !start_q && state_q == adc_seq_pkg::ST_IDLE))
    else $error("completion did not set done and clear start");

  chk_busy_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_q == adc_seq_pkg::ST_CONV) |-> !done_q)
    else $error("done set while converting");

  chk_conv_tick_count: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_end |-> (chk_ticks_q == 7'h3F))
    else $error("conversion length not sixty-four ticks");

  chk_disabled_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !en_q |=> (state_q == adc_seq_pkg::ST_IDLE))
    else $error("conversion running while disabled");

  chk_result_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !conv_end |=> ($stable(res_hi_q) && $stable(res_lo_q)))
    else $error("result changed outside completion");

  chk_result_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    conv_end |=> (res_hi_q == $past(conv_data_i[11:4]) && ist_q))
    else $error("result or status not captured");

  chk_low_res_nibble: assert property (@(posedge clk_i) disable iff (rst_i)
    (conv_end && !high_res) |=> (res_lo_q == 4'h0))
    else $error("low nibble written in eight-bit mode");

  chk_ext_ref_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    ext_ref_q |-> (pin_isolate_o[0] && ana_o.external_reference_enable))
    else $error("external reference left input-zero pin connected");

  chk_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held beyond one cycle");

  chk_launch_enters_conv: assert property (@(posedge clk_i) disable iff (rst_i)
    launch |=> (state_q == adc_seq_pkg::ST_CONV && !done_q))
    else $error("launch did not start a conversion");

  chk_ctl_write_lands: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && idx == `IDX_CTL) |=> (en_q == $past(wdat[`CTL_ENABLE])))
    else $error("enable bit write did not land");

  chk_status_read_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (take && !req.we && idx == `IDX_IRQ_STAT && dat_q[`IRQ_DONE] && !conv_end) |=> !ist_q)
    else $error("status read did not clear the done event");

endmodule : adc_sequencer_regs

// [verification/analog_source_model.sv]
`timescale 1ns/1ps

// ==========================================
// Analog pins and reference, as seen by the core
module analog_source_model (
  input wire logic clk_i,
  input wire adc_seq_pkg::analog_ctl_s ana_i,
  output logic [11:0] data_o
);
  logic flip_q = 1'b0;

  // Outside a conversion the core output is not valid, so it toggles each cycle
  always_ff @(posedge clk_i) begin
    flip_q <= ~flip_q;
  end

  // Each of the six inputs gives its own code
  assign data_o = ana_i.converting ? {ana_i.input_select, 9'h0A5} : {12{flip_q}};
endmodule : analog_source_model

// [verification/adc_sequencer_regs_bench.sv]
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h expected %h", $time, g, e); end end

module adc_sequencer_regs_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h1;
  logic [3:0] sel_val = 4'h1;
  logic [9:0] adr = 10'h000;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack;
  logic [11:0] conv_data;
  adc_seq_pkg::analog_ctl_s ana;
  logic [4:0] pin_iso;
  logic irq;
  logic [31:0] rd;
  int n;
  int error_cnt = 0;
  int check_count = 0;
  int cyc_cnt = 0;

  always #2 clk_i = ~clk_i;

  adc_sequencer_regs u_adc_sequencer_regs (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .conv_data_i(conv_data), .ana_o(ana),
    .pin_isolate_o(pin_iso), .irq_o(irq));

  analog_source_model u_analog_source_model (.clk_i(clk_i), .ana_i(ana), .data_o(conv_data));

  // ==========================================
  // Bus cycles
  task automatic xfer(input logic [7:0] idx, input logic w, input logic [7:0] v,
                      output logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= sel_val;
    adr <= {idx, 2'b00};
    dat <= {24'h000000, v};
    // No local limit: only the bench timeout ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    d = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // Register effects land on the ack edge, so outputs are looked at once settled
    @(negedge clk_i);
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] d;
    xfer(idx, 1'b1, v, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    xfer(idx, 1'b0, 8'h00, rd);
    `CHK(rd, {24'h000000, e})
  endtask : rd_chk

  // Counts cycles with a conversion running; stops once it ends
  task automatic count_busy(output int c);
    c = 0;
    for (int k = 0; k < 1200; k++) begin
      @(posedge clk_i);
      if (ana.converting === 1'b1) c++;
      else if (c > 0) break;
    end
  endtask : count_busy

  // ==========================================
  // Scenarios
  task automatic t_reset;
    rd_chk(`IDX_PIN_CFG, 8'h00);
    rd_chk(`IDX_REF_SEL, 8'h00);
    rd_chk(`IDX_CTL, 8'h00);
    rd_chk(8'h10, 8'h00);
    `CHK(ana, 10'h000)
    `CHK(irq, 1'b0)
  endtask : t_reset

  task automatic t_conv12;
    wr(`IDX_IRQ_MASK, 8'h01);
    wr(`IDX_REF_SEL, 8'h03);
    wr(`IDX_CLK_RES, 8'h40);
    wr(`IDX_CTL, 8'h92);
    `CHK(ana.channel_gate, 1'b1)
    `CHK(ana.input_select, 3'h2)
    `CHK(ana.converter_enable, 1'b1)
    `CHK(ana.high_res, 1'b1)
    `CHK(ana.reference_level_select, 2'h3)
    wr(`IDX_CTL, 8'hD2);
    count_busy(n);
    `CHK(n, 64)
    @(posedge clk_i);
    `CHK(irq, 1'b1)
    rd_chk(`IDX_CTL, 8'hB2);
    rd_chk(`IDX_RES_HI, 8'h4A);
    rd_chk(`IDX_CLK_RES, 8'h45);
    wr(`IDX_RES_HI, 8'h00);
    wr(`IDX_CLK_RES, 8'h40);
    rd_chk(`IDX_RES_HI, 8'h4A);
    rd_chk(`IDX_CLK_RES, 8'h45);
    rd_chk(`IDX_IRQ_STAT, 8'h01);
    `CHK(irq, 1'b0)
    rd_chk(`IDX_IRQ_STAT, 8'h00);
  endtask : t_conv12

  task automatic t_conv8;
    wr(`IDX_REF_SEL, 8'h01);
    wr(`IDX_CLK_RES, 8'h50);
    `CHK(ana.high_res, 1'b0)
    wr(`IDX_CTL, 8'hD5);
    count_busy(n);
    `CHK(n, 128)
    `CHK(irq, 1'b1)
    rd_chk(`IDX_RES_HI, 8'hAA);
    rd_chk(`IDX_CLK_RES, 8'h50);
    rd_chk(`IDX_IRQ_STAT, 8'h01);
  endtask : t_conv8

  task automatic t_disabled;
    wr(`IDX_CTL, 8'h65);
    count_busy(n);
    `CHK(n, 0)
    rd_chk(`IDX_CTL, 8'h65);
    rd_chk(`IDX_RES_HI, 8'hAA);
    `CHK(irq, 1'b0)
  endtask : t_disabled

  task automatic t_pins;
    wr(`IDX_PIN_CFG, 8'h12);
    `CHK(pin_iso, 5'h12)
    // Byte lane 0 not selected: the write must be dropped
    sel_val = 4'hE;
    wr(`IDX_PIN_CFG, 8'h1F);
    sel_val = 4'h1;
    `CHK(pin_iso, 5'h12)
    wr(`IDX_REF_SEL, 8'h80);
    `CHK(pin_iso, 5'h13)
    `CHK(ana.external_reference_enable, 1'b1)
    `CHK(ana.high_res, 1'b1)
    rd_chk(`IDX_PIN_CFG, 8'h12);
    rd_chk(`IDX_REF_SEL, 8'h80);
  endtask : t_pins

  // Reset in the middle of a slow conversion returns everything to idle
  task automatic t_midreset;
    wr(`IDX_CLK_RES, 8'h00);
    wr(`IDX_CTL, 8'hD0);
    rd_chk(`IDX_CTL, 8'hD0);
    `CHK(ana.converting, 1'b1)
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK(ana, 10'h000)
    `CHK(pin_iso, 5'h00)
    `CHK(irq, 1'b0)
    rd_chk(`IDX_CTL, 8'h00);
    rd_chk(`IDX_REF_SEL, 8'h00);
    rd_chk(`IDX_CLK_RES, 8'h00);
  endtask : t_midreset

  // ==========================================
  // Verdict
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // Whole run needs under two thousand cycles; this cuts a hang short
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_conv12();
    t_conv8();
    t_disabled();
    t_pins();
    t_midreset();
    tally_and_finish();
  end
endmodule : adc_sequencer_regs_bench
